// >>> pkg/rhd_consts.svh
// Constants for the root hub descriptor A register block
//----------------------------------------------------------------------
// Operation
// RULE_01: Descriptor register sits at offset 48h
// RULE_02: Software waits delay count times 2 ms
// RULE_03: Bit 12 set means no overcurrent protection
// RULE_04: Bit 12 clear lets mode bit choose
// RULE_05: Overcurrent mode resets to power switch mode
// RULE_06: Mode 0 global, 1 per port reporting
// RULE_07: Compound device bit reads zero always
// RULE_08: Bit 9 set means ports always powered
// RULE_09: Bit 9 clear lets mode bit choose
// RULE_10: Switch mode meaningful only when switched
// RULE_11: Switch mode 0 powers ports together
// RULE_12: Masked port follows port power commands
// RULE_13: Unmasked port follows global power commands
// RULE_14: Port count read-only, between 1 and 15
// RULE_15: Software writes reserved bits with reset value
// RULE_16: Mask bits 1,2 for ports; bit 0 reserved
// RULE_17: Port count resets to two
`ifndef RHD_CONSTS_SVH
`define RHD_CONSTS_SVH

//----------------------------------------------------------------------
// Register map
//----------------------------------------------------------------------
`define RHD_DESC_A_ADDR      12'h048
`define RHD_PWR_CTRL_ADDR    12'h0A0
`define RHD_INT_STATUS_ADDR  12'h0A4
`define RHD_INT_CLEAR_ADDR   12'h0A8
`define RHD_INT_ENABLE_ADDR  12'h0AC
`define RHD_PORT_STATE_ADDR  12'h0B0

//----------------------------------------------------------------------
// Field positions and reset values
//----------------------------------------------------------------------
`define RHD_DELAY_RESET      8'hFF
`define RHD_PORTS_RESET      8'h02
`define RHD_NO_OC_RESET      1'h0
`define RHD_NO_SW_RESET      1'h0
`define RHD_SW_MODE_RESET    1'h1
`define RHD_DELAY_UNIT_MS    2
`define RHD_NO_OC_BIT        12
`define RHD_OC_MODE_BIT      11
`define RHD_NO_SW_BIT        9
`define RHD_SW_MODE_BIT      8
`define RHD_NUM_PORTS        2
`define RHD_INT_BITS         3

`endif

// >>> pkg/rhd_pkg.sv
// Types for the root hub descriptor A register block
package rhd_pkg;
    // Writable descriptor fields
    typedef struct packed {
        logic [7:0] power_good_delay;
        logic       no_overcurrent_protect;
        logic       overcurrent_report_mode;
        logic       no_power_switching;
        logic       power_switch_mode;
    } rhd_desc_t;

    // Power command word, bits 0..3
    typedef struct packed {
        logic clr_port;
        logic set_port;
        logic clr_global;
        logic set_global;
    } rhd_cmd_t;

    // Bus access kinds
    typedef enum logic [1:0] {
        RHD_IDLE  = 2'b00,
        RHD_WRITE = 2'b01,
        RHD_READ  = 2'b10
    } rhd_acc_t;
endpackage

// >>> rtl/rhd_desc_a.sv
// Root hub descriptor A register with port power control over APB
`timescale 1ns/1ns
`include "rhd_consts.svh"
module rhd_desc_a
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Per-port power mask from descriptor B
    input  wire logic [2:0]  per_port_power_mask,
    // Port overcurrent inputs, index = port
    input  wire logic [2:1]  port_overcurrent,
    // Port power outputs and overcurrent reports
    output logic      [2:1]  port_power,
    output logic      [2:1]  port_oc_report,
    // Interrupt
    output logic             irq
);

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    rhd_pkg::rhd_desc_t desc_reg;        // Writable descriptor fields
    logic [7:0]         port_count_reg;  // Read-only port count
    logic [2:1]         port_pwr_reg;    // Port power state
    logic [2:1]         oc_rep_reg;      // Reported overcurrent
    logic [2:0]         sts_reg;         // Sticky event bits
    logic [2:0]         ena_reg;         // Interrupt enables
    logic [31:0]        rdata_reg;       // Read data
    logic               ready_reg;       // Access answered
    logic               err_reg;         // Error answer
    logic               irq_reg;         // Interrupt level
    logic               strap_done_reg;  // Post-reset settle

    //------------------------------------------------------------------
    // Decode
    //------------------------------------------------------------------
    rhd_pkg::rhd_acc_t acc;              // Access kind this cycle
    logic              wr_desc;          // Write to descriptor
    logic              wr_pwr;           // Write to power command
    logic              wr_clr;           // Write to interrupt clear
    logic              wr_ena;           // Write to interrupt enable
    logic              mapped;           // Address is mapped
    rhd_pkg::rhd_cmd_t cmd;              // Power command bits
    logic [1:0]        port_sel;         // Port addressed by command
    logic [2:0]        ev;               // Hardware events
    logic [2:1]        pwr_next;         // Next port power
    logic [2:1]        oc_next;          // Next overcurrent report

    // Address match helper
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] r);
        hit = (a[11:2] == r[11:2]);
    endfunction

    // Access completes on the second APB phase
    always_comb
    begin
        if (psel && penable && !ready_reg)
            acc = pwrite ? rhd_pkg::RHD_WRITE : rhd_pkg::RHD_READ;
        else
            acc = rhd_pkg::RHD_IDLE;
    end

    // Register selection
    assign mapped  = hit(paddr, `RHD_DESC_A_ADDR)     // RULE_01
                   | hit(paddr, `RHD_PWR_CTRL_ADDR)
                   | hit(paddr, `RHD_INT_STATUS_ADDR)
                   | hit(paddr, `RHD_INT_CLEAR_ADDR)
                   | hit(paddr, `RHD_INT_ENABLE_ADDR)
                   | hit(paddr, `RHD_PORT_STATE_ADDR);
    assign wr_desc = (acc == rhd_pkg::RHD_WRITE)
                   && hit(paddr, `RHD_DESC_A_ADDR);   // RULE_01
    assign wr_pwr  = (acc == rhd_pkg::RHD_WRITE)
                   && hit(paddr, `RHD_PWR_CTRL_ADDR);
    assign wr_clr  = (acc == rhd_pkg::RHD_WRITE)
                   && hit(paddr, `RHD_INT_CLEAR_ADDR);
    assign wr_ena  = (acc == rhd_pkg::RHD_WRITE)
                   && hit(paddr, `RHD_INT_ENABLE_ADDR);
    assign cmd      = wr_pwr && pstrb[0] ? pwdata[3:0] : 4'h0;
    assign port_sel = pwdata[5:4];

    //------------------------------------------------------------------
    // APB answer: one wait state, error on unmapped
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ready_reg <= (acc != rhd_pkg::RHD_IDLE);
            err_reg   <= (acc != rhd_pkg::RHD_IDLE) && !mapped;
            if (acc == rhd_pkg::RHD_READ)
            begin
                if (hit(paddr, `RHD_DESC_A_ADDR))
                    // Reserved 23..13 and bit 10 read zero
                    rdata_reg <= {desc_reg.power_good_delay,  // RULE_02
                                  11'h000,
                                  desc_reg.no_overcurrent_protect,
                                  desc_reg.overcurrent_report_mode,
                                  1'b0,                       // RULE_07
                                  desc_reg.no_power_switching,
                                  desc_reg.power_switch_mode,
                                  port_count_reg};            // RULE_14
                else if (hit(paddr, `RHD_INT_STATUS_ADDR))
                    rdata_reg <= {29'h0, sts_reg};
                else if (hit(paddr, `RHD_INT_ENABLE_ADDR))
                    rdata_reg <= {29'h0, ena_reg};
                else if (hit(paddr, `RHD_PORT_STATE_ADDR))
                    rdata_reg <= {28'h0, oc_rep_reg, port_pwr_reg};
                else
                    rdata_reg <= 32'h0000_0000;
            end
        end
    end

    //------------------------------------------------------------------
    // Descriptor fields, byte lanes honoured
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            desc_reg.power_good_delay        <= `RHD_DELAY_RESET;
            desc_reg.no_overcurrent_protect  <= `RHD_NO_OC_RESET;
            desc_reg.overcurrent_report_mode <= `RHD_SW_MODE_RESET; // RULE_05
            desc_reg.no_power_switching      <= `RHD_NO_SW_RESET;
            desc_reg.power_switch_mode       <= `RHD_SW_MODE_RESET;
        end
        else if (wr_desc)
        begin
            if (pstrb[3])
                desc_reg.power_good_delay <= pwdata[31:24];
            if (pstrb[1])
            begin
                desc_reg.no_overcurrent_protect  <= pwdata[`RHD_NO_OC_BIT];
                desc_reg.overcurrent_report_mode <= pwdata[`RHD_OC_MODE_BIT];
                desc_reg.no_power_switching      <= pwdata[`RHD_NO_SW_BIT];
                desc_reg.power_switch_mode       <= pwdata[`RHD_SW_MODE_BIT];
            end
        end
    end

    // Port count is fixed; writes ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_count_reg <= `RHD_PORTS_RESET; // RULE_17
        else
            port_count_reg <= `RHD_PORTS_RESET; // RULE_14
    end

    //------------------------------------------------------------------
    // Port power switching
    //------------------------------------------------------------------
    always_comb
    begin
        pwr_next = port_pwr_reg;
        if (desc_reg.no_power_switching)
            pwr_next = 2'b11;                                 // RULE_08
        else if (!desc_reg.power_switch_mode)                 // RULE_09
        begin
            // Ganged: any command drives both ports
            if (cmd.set_global || cmd.set_port)
                pwr_next = 2'b11;                             // RULE_11
            else if (cmd.clr_global || cmd.clr_port)
                pwr_next = 2'b00;                             // RULE_11
        end
        else
        begin
            for (int p = 1; p <= `RHD_NUM_PORTS; p++)
            begin
                if (per_port_power_mask[p])                   // RULE_16
                begin
                    // Masked port hears only port commands
                    if (cmd.set_port && port_sel == p[1:0])
                        pwr_next[p] = 1'b1;                   // RULE_12
                    else if (cmd.clr_port && port_sel == p[1:0])
                        pwr_next[p] = 1'b0;                   // RULE_12
                end
                else
                begin
                    // Unmasked port hears only global commands
                    if (cmd.set_global)
                        pwr_next[p] = 1'b1;                   // RULE_13
                    else if (cmd.clr_global)
                        pwr_next[p] = 1'b0;                   // RULE_13
                end
            end
        end
    end

    // Power state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_pwr_reg <= 2'b00;
        else
            port_pwr_reg <= pwr_next; // RULE_10
    end

    //------------------------------------------------------------------
    // Overcurrent reporting
    //------------------------------------------------------------------
    always_comb
    begin
        if (desc_reg.no_overcurrent_protect)
            oc_next = 2'b00;                                  // RULE_03
        else if (!desc_reg.overcurrent_report_mode)           // RULE_04
            oc_next = {2{|port_overcurrent}};                 // RULE_06
        else
            oc_next = port_overcurrent;                       // RULE_06
    end

    // Report register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oc_rep_reg <= 2'b00;
        else
            oc_rep_reg <= oc_next;
    end

    //------------------------------------------------------------------
    // Interrupts: bit0 port1 oc, bit1 port2 oc, bit2 power change
    //------------------------------------------------------------------
    assign ev = {(pwr_next != port_pwr_reg),
                 oc_next & ~oc_rep_reg};

    // Sticky status; set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sts_reg <= 3'h0;
        else
            sts_reg <= (sts_reg & ~(wr_clr ? pwdata[2:0] : 3'h0)) | ev;
    end

    // Enable register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ena_reg <= 3'h0;
        else if (wr_ena)
            ena_reg <= pwdata[2:0];
    end

    // Interrupt level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(((sts_reg & ~(wr_clr ? pwdata[2:0] : 3'h0)) | ev)
                         & (wr_ena ? pwdata[2:0] : ena_reg));
    end

    // Marks first cycle after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strap_done_reg <= 1'b0;
        else
            strap_done_reg <= 1'b1;
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    assign prdata         = rdata_reg;
    assign pready         = ready_reg;
    assign pslverr        = err_reg;
    assign port_power     = port_pwr_reg;
    assign port_oc_report = oc_rep_reg;
    assign irq            = irq_reg;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    a_mode_reset_match: assert property (@(posedge pclk) // RULE_05
        $rose(strap_done_reg) |-> desc_reg.overcurrent_report_mode
                                  == desc_reg.power_switch_mode)
        else $error("Overcurrent mode not equal to switch mode at reset");
    a_compound_zero: assert property (@(posedge pclk) // RULE_07
        disable iff (!presetn)
        (acc == rhd_pkg::RHD_READ && hit(paddr, `RHD_DESC_A_ADDR))
        |=> !prdata[10])
        else $error("Compound device bit read as one");
    a_port_count: assert property (@(posedge pclk) // RULE_14
        disable iff (!presetn)
        port_count_reg >= 8'h01 && port_count_reg <= 8'h0F)
        else $error("Port count out of range");
    a_count_reset_two: assert property (@(posedge pclk) // RULE_17
        disable iff (!presetn) port_count_reg == 8'h02)
        else $error("Port count not two");
    a_read_addr_48: assert property (@(posedge pclk) // RULE_01
        disable iff (!presetn)
        (acc == rhd_pkg::RHD_READ && paddr == 12'h048)
        |=> pready && !pslverr && prdata[7:0] == 8'h02)
        else $error("Descriptor not answered at 48h");
    a_unprotected_quiet: assert property (@(posedge pclk) // RULE_03
        disable iff (!presetn)
        desc_reg.no_overcurrent_protect && $stable(desc_reg)
        |=> port_oc_report == 2'b00)
        else $error("Overcurrent reported without protection");
    a_global_report: assert property (@(posedge pclk) // RULE_06
        disable iff (!presetn)
        !desc_reg.no_overcurrent_protect
        && !desc_reg.overcurrent_report_mode && |port_overcurrent
        |=> port_oc_report == 2'b11)
        else $error("Global overcurrent not reported on all ports");
    a_always_powered: assert property (@(posedge pclk) // RULE_08
        disable iff (!presetn)
        desc_reg.no_power_switching |=> port_power == 2'b11)
        else $error("Ports not powered with no switching");
    a_ganged_power: assert property (@(posedge pclk) // RULE_11
        disable iff (!presetn)
        !desc_reg.no_power_switching && !desc_reg.power_switch_mode
        |=> port_power[1] == port_power[2])
        else $error("Ganged ports differ");
    a_masked_global: assert property (@(posedge pclk) // RULE_12
        disable iff (!presetn)
        !desc_reg.no_power_switching && desc_reg.power_switch_mode
        && per_port_power_mask[1] && !cmd.set_port && !cmd.clr_port
        |=> $stable(port_power[1]))
        else $error("Masked port moved without port command");
    a_unmasked_port: assert property (@(posedge pclk) // RULE_13
        disable iff (!presetn)
        !desc_reg.no_power_switching && desc_reg.power_switch_mode
        && !per_port_power_mask[2] && !cmd.set_global
        && !cmd.clr_global |=> $stable(port_power[2]))
        else $error("Unmasked port moved without global command");
    c_desc_write: cover property (@(posedge pclk) wr_desc);
    c_port_cmd: cover property (@(posedge pclk) cmd.set_port);
    c_irq_high: cover property (@(posedge pclk) $rose(irq));
    c_unmapped: cover property (@(posedge pclk) pslverr);

endmodule

// >>> test/rhd_port_model.sv
// Behavioural model of the root hub ports beside the descriptor block
`timescale 1ns/1ns
module rhd_port_model
(
    // Clock
    input  wire logic       pclk,
    // Bench controls: fault per port, port power mask setting
    input  wire logic [2:1] fault_req,
    input  wire logic [2:1] mask_cfg,
    // Toward the block: sensor levels and power mask
    output logic      [2:1] port_overcurrent,
    output logic      [2:0] per_port_power_mask
);
    // Sensors start quiet so the block sees no event at power up
    initial port_overcurrent = 2'b00;

    // Current sensors report a fault one clock after it appears
    always @(posedge pclk)
        port_overcurrent <= fault_req;

    // Lane 0 of the mask is reserved and always driven low
    assign per_port_power_mask = {mask_cfg, 1'b0};
endmodule

// >>> test/testbench.sv
// Self-checking bench for the root hub descriptor A block
`timescale 1ns/1ns
`include "rhd_consts.svh"
module testbench;
    //------------------------------------------------------------------
    // Signals
    //------------------------------------------------------------------
    logic        pclk    = 1'b0;   // 125 MHz clock
    logic        presetn = 1'b0;   // Reset, active low
    logic        psel    = 1'b0;   // APB select
    logic        penable = 1'b0;   // APB enable
    logic        pwrite  = 1'b0;   // APB direction
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:1]  fault_req = 2'b00; // Faults commanded to the ports
    logic [2:1]  mask_cfg  = 2'b01; // Port 1 masked, port 2 global
    logic [2:0]  ppm;
    logic [2:1]  port_oc;
    logic [2:1]  port_power;
    logic [2:1]  port_oc_report;
    logic        irq;
    logic [31:0] rd_data;           // Last read data
    logic        rd_err;            // Last error response
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cycles    = 0;

    // Clock generator
    always #4 pclk = ~pclk;

    //------------------------------------------------------------------
    // Instances
    //------------------------------------------------------------------
    rhd_desc_a u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .per_port_power_mask(ppm),
        .port_overcurrent(port_oc), .port_power(port_power),
        .port_oc_report(port_oc_report), .irq(irq));

    rhd_port_model u_ports (.pclk(pclk), .fault_req(fault_req),
        .mask_cfg(mask_cfg), .port_overcurrent(port_oc),
        .per_port_power_mask(ppm));

    //------------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------------
    // Verdict and end of run
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One comparison
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h, seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Wait for the answer; only the bench timeout ends a hang
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
            n++;
        end
        // One wait state in the access phase
        chk("wait_states", 32'h1, n);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Register read, masked compare
    task automatic rchk(input string n, input logic [11:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd_data & m);
    endtask

    // Power command, then port power compare
    task automatic pcmd(input logic [31:0] c, input logic [1:0] e);
        wr(`RHD_PWR_CTRL_ADDR, c);
        @(posedge pclk);
        chk("port_power", {30'h0, e}, {30'h0, port_power});
    endtask

    // Descriptor write, then port level compare after it settles
    // oc selects the overcurrent report, else port power
    task automatic dset(input logic [31:0] d, input string n,
                        input logic [1:0] e, input bit oc);
        wr(`RHD_DESC_A_ADDR, d);
        repeat (3) @(posedge pclk);
        chk(n, {30'h0, e},
            {30'h0, (oc ? port_oc_report : port_power)});
    endtask

    // Hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset image at the fixed offset
        rchk("desc_reset", `RHD_DESC_A_ADDR, 32'hFFFFFFFF, 32'hFF000902);
        // Reserved bits kept at zero; type bit and port count refuse
        wr(`RHD_DESC_A_ADDR, 32'h12001FFF);
        rchk("desc_fields", `RHD_DESC_A_ADDR, 32'hFFFFFFFF, 32'h12001B02);
        chk("power_good_delay", 32'h12, {24'h0, rd_data[31:24]});
        // Unmapped place answers with an error and zero data
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, rd_err});
        chk("unmapped_data", 32'h0, rd_data);
        // Per-port mode: port 1 masked, port 2 global
        dset(32'hFF000902, "port_power", 2'b11, 1'b0);
        pcmd(32'h00000002, 2'b01);
        pcmd(32'h00000018, 2'b00);
        pcmd(32'h00000001, 2'b10);
        pcmd(32'h00000014, 2'b11);
        pcmd(32'h00000002, 2'b01);
        pcmd(32'h00000024, 2'b01);
        pcmd(32'h00000018, 2'b00);
        // Ganged mode moves both ports together
        dset(32'hFF000802, "port_power", 2'b00, 1'b0);
        pcmd(32'h00000001, 2'b11);
        pcmd(32'h00000018, 2'b00);
        // Power changes have latched the power event bit
        rchk("power_event", `RHD_INT_STATUS_ADDR, 32'h4, 32'h4);
        // No switching: ports always powered
        dset(32'hFF000A02, "port_power", 2'b11, 1'b0);
        // Back to switched mode: ports keep their power
        dset(32'hFF000902, "port_power", 2'b11, 1'b0);
        wr(`RHD_INT_CLEAR_ADDR, 32'h00000007);
        wr(`RHD_INT_ENABLE_ADDR, 32'h00000001);
        rchk("status", `RHD_INT_STATUS_ADDR, 32'h7, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        fault_req <= 2'b01;
        repeat (4) @(posedge pclk);
        chk("oc_report", 32'h1, {30'h0, port_oc_report});
        chk("irq", 32'h1, {31'h0, irq});
        rchk("status", `RHD_INT_STATUS_ADDR, 32'h3, 32'h1);
        rchk("port_state", `RHD_PORT_STATE_ADDR, 32'hC, 32'h4);
        wr(`RHD_INT_CLEAR_ADDR, 32'h00000001);
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        rchk("status", `RHD_INT_STATUS_ADDR, 32'h1, 32'h0);
        // Masked event sets status but leaves irq low
        fault_req <= 2'b00;
        wr(`RHD_INT_ENABLE_ADDR, 32'h00000000);
        rchk("enable", `RHD_INT_ENABLE_ADDR, 32'h7, 32'h0);
        fault_req <= 2'b01;
        repeat (4) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        rchk("status", `RHD_INT_STATUS_ADDR, 32'h1, 32'h1);
        // Collective reporting, then no protection
        dset(32'hFF000102, "oc_report", 2'b11, 1'b1);
        dset(32'hFF001102, "oc_report", 2'b00, 1'b1);
        rchk("port_state", `RHD_PORT_STATE_ADDR, 32'hC, 32'h0);
        stop_test();
    end
endmodule
